// ===== asf_pkg.sv
package asf_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] ASF_FLAGS_OFS = 12'h000;
  localparam logic [11:0] ASF_EXEC_OFS = 12'h004;
  localparam logic [11:0] ASF_OPER_OFS = 12'h008;
  localparam logic [11:0] ASF_RESULT_OFS = 12'h00C;
  // ----------------------------------------
  // flag bit positions
  // ----------------------------------------
  localparam int ASF_C_BIT = 0;
  localparam int ASF_DC_BIT = 1;
  localparam int ASF_Z_BIT = 2;
  localparam int ASF_OV_BIT = 3;
  localparam int ASF_N_BIT = 4;
  localparam logic [7:0] ASF_IMPL_MASK = 8'h1F;
  localparam logic [7:0] ASF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] ASF_ALL_FLAGS = 8'h1F;
  // ----------------------------------------
  // exec register fields
  // ----------------------------------------
  localparam int ASF_OPC_LSB = 0;
  localparam int ASF_DEST_BIT = 8;
  localparam int ASF_BITSEL_LSB = 12;
  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    ASF_ADD_REG, ASF_ADD_LIT, ASF_SUB_LIT, ASF_SUB_REG,
    ASF_ROT_RIGHT, ASF_ROT_LEFT, ASF_AND_OP, ASF_ZERO_FILL,
    ASF_BIT_CLEAR, ASF_BIT_SET, ASF_NIB_SWAP, ASF_REG_COPY, ASF_ACC_COPY
  } asf_op_e;
  typedef enum logic {ASF_IDLE, ASF_BUSY} asf_st_e;
endpackage : asf_pkg

// ===== asf_alu.sv
`timescale 1ns/1ns
module asf_alu
  import asf_pkg::*;
(
  // operands
  input wire asf_pkg::asf_op_e op,
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] flags_in,
  // result
  output logic [7:0] result,
  output logic [7:0] flags_out,
  output logic [7:0] flags_touched
);
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction : add9

  function automatic logic nib_c(input logic [7:0] a, input logic [7:0] b,
                                 input logic cin);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    nib_c = s[4];
  endfunction : nib_c

  wire is_add = (op == ASF_ADD_REG) || (op == ASF_ADD_LIT);
  wire is_sub = (op == ASF_SUB_REG) || (op == ASF_SUB_LIT);
  // subtract = a + ~b + 1, so carries read as not-borrow
  wire [7:0] add_b = is_sub ? ~opnd_b : opnd_b;
  wire add_cin = is_sub;
  wire [8:0] sum = add9(opnd_a, add_b, add_cin);
  wire sum_dc = nib_c(opnd_a, add_b, add_cin);
  wire sum_ov = (opnd_a[7] == add_b[7]) && (sum[7] != opnd_a[7]);
  wire [7:0] bit_mask = 8'h01 << bit_sel;

  always_comb begin
    result = opnd_a;
    flags_out = flags_in;
    flags_touched = 8'h00;
    unique case (op)
      ASF_ADD_REG, ASF_ADD_LIT, ASF_SUB_LIT, ASF_SUB_REG: begin
        result = sum[7:0];
        flags_out[ASF_C_BIT] = sum[8];
        flags_out[ASF_DC_BIT] = sum_dc;
        flags_out[ASF_OV_BIT] = sum_ov;
        flags_touched = ASF_ALL_FLAGS;
      end
      ASF_ROT_RIGHT: begin
        result = {flags_in[ASF_C_BIT], opnd_a[7:1]};
        flags_out[ASF_C_BIT] = opnd_a[0];
        flags_out[ASF_DC_BIT] = opnd_a[4];
        flags_touched = 8'h17;
      end
      ASF_ROT_LEFT: begin
        result = {opnd_a[6:0], flags_in[ASF_C_BIT]};
        flags_out[ASF_C_BIT] = opnd_a[7];
        flags_out[ASF_DC_BIT] = opnd_a[3];
        flags_touched = 8'h17;
      end
      ASF_AND_OP: begin
        result = opnd_a & opnd_b;
        flags_touched = 8'h14;
      end
      ASF_ZERO_FILL: begin
        result = 8'h00;
        flags_touched = 8'h04;
      end
      ASF_BIT_CLEAR: result = opnd_a & ~bit_mask;
      ASF_BIT_SET: result = opnd_a | bit_mask;
      ASF_NIB_SWAP: result = {opnd_a[3:0], opnd_a[7:4]};
      ASF_REG_COPY: result = opnd_a;
      ASF_ACC_COPY: result = opnd_b;
      default: result = opnd_a;
    endcase
    if (flags_touched[ASF_Z_BIT]) begin
      flags_out[ASF_Z_BIT] = (result == 8'h00);
    end
    if (flags_touched[ASF_N_BIT]) begin
      flags_out[ASF_N_BIT] = result[7];
    end
  end
endmodule : asf_alu

// ===== asf_apb.sv
`timescale 1ns/1ns
module asf_apb (
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // decode
  output logic wr_stb,
  output logic rd_stb,
  output logic [11:0] word_addr
);
  // zero wait states: pready is held high by the top
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && !penable && !pwrite;
  assign word_addr = {paddr[11:2], 2'b00};
endmodule : asf_apb

// ===== asf_status.sv
`timescale 1ns/1ns
// Function
// - negative flag follows result bit seven
// - overflow flag on signed wrap
// - zero flag when result is zero
// - add/sub nibble carry from bit three
// - add/sub carry from top bit
// - subtract adds complement; carries mean no-borrow
// - rotates load nibble carry from bit 4/3
// - rotates load carry with shifted-out bit
// - flag-writing op targeting flags drops result
// - zero fill of flags sets only zero
// - bit/swap/copy ops write result unchanged
// - flag register used as operand a only when flags are the destination; rotates always take their carry-in from it
module asf_status
  import asf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flag view
  output logic [7:0] arith_flags_out
);
  import asf_pkg::*;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_stb;
  logic rd_stb;
  logic [11:0] word_addr;

  asf_apb u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .word_addr(word_addr)
  );

  wire hit_flags = (word_addr == ASF_FLAGS_OFS);
  wire hit_exec = (word_addr == ASF_EXEC_OFS);
  wire hit_oper = (word_addr == ASF_OPER_OFS);
  wire hit_result = (word_addr == ASF_RESULT_OFS);
  wire hit_any = hit_flags || hit_exec || hit_oper || hit_result;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] arith_flags;
  logic [7:0] operand_a;
  logic [7:0] operand_b;
  logic [7:0] result_reg;

  wire exec_go = wr_stb && hit_exec;
  wire [3:0] opc_raw = pwdata[ASF_OPC_LSB +: 4];
  wire opc_ok = (opc_raw <= 4'(ASF_ACC_COPY));
  wire dest_flags = pwdata[ASF_DEST_BIT];
  wire [2:0] bit_sel = pwdata[ASF_BITSEL_LSB +: 3];
  // flag register as source when destination is flags
  wire [7:0] src_a = dest_flags ? (arith_flags & ASF_IMPL_MASK) : operand_a;

  logic [7:0] alu_result;
  logic [7:0] alu_flags;
  logic [7:0] alu_touched;

  asf_alu u_alu (
    .op(asf_op_e'(opc_raw)),
    .opnd_a(src_a),
    .opnd_b(operand_b),
    .bit_sel(bit_sel),
    .flags_in(arith_flags),
    .result(alu_result),
    .flags_out(alu_flags),
    .flags_touched(alu_touched)
  );

  // flag-affecting op into flags keeps only its flags
  wire [7:0] exec_flags = (dest_flags && alu_touched == 8'h00) ? alu_result :
                          alu_flags;
  wire [7:0] next_arith_flags = (exec_go && opc_ok) ? (exec_flags & ASF_IMPL_MASK) :
                                (wr_stb && hit_flags) ? (pwdata[7:0] & ASF_IMPL_MASK) :
                                arith_flags;
  wire [31:0] rd_mux = hit_flags ? {24'h0, arith_flags & ASF_IMPL_MASK} :
                       hit_oper ? {16'h0, operand_b, operand_a} :
                       hit_result ? {24'h0, result_reg} : 32'h0;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arith_flags <= ASF_FLAGS_RESET;
      operand_a <= 8'h00;
      operand_b <= 8'h00;
      result_reg <= 8'h00;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      arith_flags <= next_arith_flags;
      pready <= 1'b1;
      if (wr_stb && hit_oper) begin
        operand_a <= pwdata[7:0];
        operand_b <= pwdata[15:8];
      end
      if (exec_go && opc_ok && !dest_flags) begin
        result_reg <= alu_result;
      end
      if (rd_stb) begin
        prdata <= rd_mux;
      end
      pslverr <= psel && !penable && (!hit_any || (pwrite && hit_exec && !opc_ok));
    end
  end

  assign arith_flags_out = arith_flags;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    arith_flags[7:5] == 3'b000) else $error("upper flag bits set");
  a_neg_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !dest_flags && alu_touched[4] |=> arith_flags[4] == result_reg[7])
    else $error("negative flag wrong");
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !dest_flags && alu_touched[2] |=> arith_flags[2] == (result_reg == 8'h00))
    else $error("zero flag wrong");
  a_sub_carry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !dest_flags && opc_raw == 4'(ASF_SUB_REG) |=>
    arith_flags[0] == ($past(operand_a) >=
    $past(operand_b))) else $error("borrow polarity wrong");
  a_rot_carry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && opc_raw == 4'(ASF_ROT_LEFT) |=> arith_flags[0] == $past(src_a[7]))
    else $error("rotate carry wrong");
  a_rot_nib: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && opc_raw == 4'(ASF_ROT_RIGHT) |=> arith_flags[1] == $past(src_a[4]))
    else $error("rotate nibble carry wrong");
  a_fill_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && dest_flags && opc_raw == 4'(ASF_ZERO_FILL) |=>
    arith_flags == (($past(arith_flags) & 8'h1B) | 8'h04)) else $error("zero fill wrong");
  a_swap_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && dest_flags && opc_raw == 4'(ASF_NIB_SWAP) |=>
    arith_flags == ({$past(arith_flags[3:0]), $past(arith_flags[7:4])} & 8'h1F))
    else $error("swap into flags wrong");
  a_keep_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && dest_flags |=> $stable(result_reg)) else $error("result written");
  c_sub_op: cover property (@(posedge sys_clk) exec_go && opc_raw == 4'(ASF_SUB_LIT));
  c_fill_flags: cover property (@(posedge sys_clk) exec_go && dest_flags &&
    opc_raw == 4'(ASF_ZERO_FILL));
  c_overflow: cover property (@(posedge sys_clk) exec_go && alu_flags[3]);
  c_logic_zero: cover property (@(posedge sys_clk) exec_go && opc_raw == 4'(ASF_AND_OP) &&
    alu_flags[2]);

  // ----------------------------------------
  // arithmetic flag checks
  // ----------------------------------------
  // carry and nibble carry worked out from the operands, not from the adder; overflow also uses result_reg[7]
  a_add_carry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !dest_flags && opc_raw == 4'(ASF_ADD_REG) |=>
    arith_flags[0] == (({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)}) > 9'h0FF))
    else $error("add carry wrong");
  a_add_nibble: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !dest_flags && opc_raw == 4'(ASF_ADD_REG) |=>
    arith_flags[1] == (({1'b0, $past(operand_a[3:0])} + {1'b0, $past(operand_b[3:0])}) >
    5'h0F)) else $error("add nibble carry wrong");
  a_add_ovf: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !dest_flags && opc_raw == 4'(ASF_ADD_REG) |=>
    arith_flags[3] == (($past(operand_a[7]) == $past(operand_b[7])) &&
    (result_reg[7] != $past(operand_a[7])))) else $error("overflow flag wrong");
  a_bad_op_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    exec_go && !opc_ok |=> $stable(arith_flags)) else $error("illegal op changed flags");
endmodule : asf_status

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  import asf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] arith_flags_out;
  int mismatches = 0;
  int checked = 0;
  always #25 sys_clk = ~sys_clk;
  asf_status u_asf_status (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .arith_flags_out(arith_flags_out));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // idle edge first, so a release never meets the next setup in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [7:0] f, a, b, input logic [3:0] op, input logic dst,
                     input logic [2:0] bs, input logic [7:0] ef, er);
    logic [31:0] q;
    logic e;
    apb(1'b1, ASF_FLAGS_OFS, {24'h0, f}, q, e);
    apb(1'b1, ASF_OPER_OFS, {16'h0, b, a}, q, e);
    apb(1'b1, ASF_EXEC_OFS, {17'h0, bs, 3'h0, dst, 4'h0, op}, q, e);
    chk("exec_err", 32'h0, {31'h0, e});
    apb(1'b0, ASF_FLAGS_OFS, 32'h0, q, e);
    chk("flags_rd", {24'h0, ef}, q);
    chk("flags_out", {24'h0, ef}, {24'h0, arith_flags_out});
    if (dst == 1'b0) begin
      apb(1'b0, ASF_RESULT_OFS, 32'h0, q, e);
      chk("result", {24'h0, er}, q);
    end
  endtask : run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    apb(1'b0, ASF_FLAGS_OFS, 32'h0, q, e);
    chk("flags_reset", 32'h0, q);
    apb(1'b1, ASF_FLAGS_OFS, 32'h0000_00FF, q, e);
    apb(1'b0, ASF_FLAGS_OFS, 32'h0, q, e);
    chk("flags_upper", 32'h0000_001F, q);
  endtask : t_reset
  task automatic t_add();
    run(8'h00, 8'h88, 8'h88, ASF_ADD_REG, 1'b0, 3'h0, 8'h0B, 8'h10);
    run(8'h1F, 8'h80, 8'h80, ASF_ADD_LIT, 1'b0, 3'h0, 8'h0D, 8'h00);
    run(8'h00, 8'h40, 8'h40, ASF_ADD_REG, 1'b0, 3'h0, 8'h18, 8'h80);
  endtask : t_add
  task automatic t_sub();
    run(8'h00, 8'h10, 8'h01, ASF_SUB_REG, 1'b0, 3'h0, 8'h01, 8'h0F);
    run(8'h1F, 8'h00, 8'h01, ASF_SUB_LIT, 1'b0, 3'h0, 8'h10, 8'hFF);
  endtask : t_sub
  task automatic t_rot();
    // overflow flag set beforehand must survive a rotate
    run(8'h09, 8'h10, 8'h00, ASF_ROT_RIGHT, 1'b0, 3'h0, 8'h1A, 8'h88);
    run(8'h00, 8'h89, 8'h00, ASF_ROT_LEFT, 1'b0, 3'h0, 8'h03, 8'h12);
  endtask : t_rot
  task automatic t_dest();
    run(8'h01, 8'h00, 8'h0F, ASF_ADD_REG, 1'b1, 3'h0, 8'h02, 8'h00);
    run(8'h1B, 8'h00, 8'h00, ASF_ZERO_FILL, 1'b1, 3'h0, 8'h1F, 8'h00);
  endtask : t_dest
  task automatic t_keep();
    run(8'h00, 8'h00, 8'h00, ASF_BIT_SET, 1'b1, 3'h2, 8'h04, 8'h00);
    run(8'h1F, 8'h00, 8'h00, ASF_BIT_CLEAR, 1'b1, 3'h4, 8'h0F, 8'h00);
    run(8'h10, 8'h00, 8'h00, ASF_NIB_SWAP, 1'b1, 3'h0, 8'h01, 8'h00);
    run(8'h00, 8'h00, 8'h15, ASF_ACC_COPY, 1'b1, 3'h0, 8'h15, 8'h00);
    run(8'h0A, 8'h00, 8'h00, ASF_REG_COPY, 1'b1, 3'h0, 8'h0A, 8'h00);
    run(8'h01, 8'hF0, 8'h0F, ASF_AND_OP, 1'b0, 3'h0, 8'h05, 8'h00);
    run(8'h00, 8'h80, 8'hC3, ASF_AND_OP, 1'b0, 3'h0, 8'h10, 8'h80);
    run(8'h0A, 8'h00, 8'h00, ASF_REG_COPY, 1'b1, 3'h0, 8'h0A, 8'h00);
  endtask : t_keep
  task automatic t_err();
    logic [31:0] q;
    logic e;
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_rd", 32'h0, q);
    // opcode past the table must leave the flags alone
    apb(1'b1, ASF_EXEC_OFS, 32'h0000_000D, q, e);
    chk("bad_op_err", 32'h1, {31'h0, e});
    apb(1'b0, ASF_FLAGS_OFS, 32'h0, q, e);
    chk("bad_op_flags", 32'h0000_000A, q);
  endtask : t_err
  // ----------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_add();
    t_sub();
    t_rot();
    t_dest();
    t_keep();
    t_err();
    test_done();
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule : tb
